// File: adcs_dsp_model.sv
// Processor-side model driving the register port and the comparators
`timescale 1ns/1ns
module adcs_dsp_model
    import adcs_pkg::*;
(
    // Requests from the bench
    input wire logic go,
    input wire logic [2:0] go_addr,
    input wire logic [7:0] go_data,
    input wire logic [3:0] msb_code,
    input wire logic [3:0] lsb_code,
    // Converter side
    input wire logic msb_phase,
    input wire logic lsb_phase,
    output adcs_ext_wr_t ext,
    output logic [3:0] msb_flash,
    output logic [3:0] lsb_flash
);
    always_comb begin
        ext.wr = go;
        ext.addr = go_addr;
        // Idle data is inverted so a stray capture shows up
        ext.data = go ? go_data : ~go_data;
    end
    // Outside its phase a stage shows junk, so a late sample is caught
    assign msb_flash = msb_phase ? msb_code : ~msb_code;
    assign lsb_flash = lsb_phase ? lsb_code : ~lsb_code;
endmodule

// File: adcs_params.svh
// Constants for the converter sequencer
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// Control register index and its fields
`define ADCS_CTRL_INDEX 3'h6
`define ADCS_BIT_START 0
`define ADCS_BIT_RATE 1
`define ADCS_BIT_ENABLE 2
`define ADCS_BIT_BUSY 3

// Clock and sample rates
`define ADCS_CLK_HZ 100000000
`define ADCS_CLK_NS 10
`define ADCS_RATE_LO_HZ 10000
`define ADCS_RATE_HI_HZ 16000
`define ADCS_PERIOD_LO_CYC (`ADCS_CLK_HZ / `ADCS_RATE_LO_HZ)
`define ADCS_PERIOD_HI_CYC (`ADCS_CLK_HZ / `ADCS_RATE_HI_HZ)

// Phase times in ns and cycles
`define ADCS_AZ_NS 1000
`define ADCS_STAGE_NS 500
`define ADCS_CONV_MAX_NS 2000
`define ADCS_AZ_CYC ((`ADCS_AZ_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_STAGE_CYC ((`ADCS_STAGE_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_CONV_MAX_CYC (`ADCS_CONV_MAX_NS / `ADCS_CLK_NS)

// Reset values
`define ADCS_CTRL_RESET 2'h0
`define ADCS_RESULT_RESET 8'h00

`endif

// File: adcs_pkg.sv
// Types shared by the converter sequencer files
package adcs_pkg;

    typedef struct packed {
        logic enable;
        logic rate_hi;
    } adcs_ctrl_t;

    typedef struct packed {
        logic wr;
        logic [2:0] addr;
        logic [7:0] data;
    } adcs_ext_wr_t;

    typedef enum logic [3:0] {
        ADCS_IDLE = 4'h1,
        ADCS_ZERO = 4'h2,
        ADCS_MSB = 4'h4,
        ADCS_LSB = 4'h8
    } adcs_state_t;

endpackage

// File: adcs_sample_timer.sv
// Sample period timer pacing the converter
`timescale 1ns/1ns
`include "adcs_params.svh"
module adcs_sample_timer
    import adcs_pkg::*;
#(
    parameter int SLOW_PERIOD = `ADCS_PERIOD_LO_CYC,
    parameter int FAST_PERIOD = `ADCS_PERIOD_HI_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic restart,
    input wire logic run,
    input wire logic rate_hi,
    // Period boundary
    output logic tick
);
    localparam logic [15:0] SLOW_LAST = 16'(SLOW_PERIOD - 1);
    localparam logic [15:0] FAST_LAST = 16'(FAST_PERIOD - 1);

    logic [15:0] count;
    logic [15:0] next_count;
    logic [15:0] last;

    always_comb begin
        last = rate_hi ? FAST_LAST : SLOW_LAST;
        tick = ce && run && !restart && (count == last);
        next_count = count;
        if (restart || !run || tick) begin
            next_count = 16'h0000;
        end else begin
            next_count = count + 16'h0001;
        end
    end

    // Frozen while the clock enable is low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
        end else if (ce) begin
            count <= next_count;
        end
    end
endmodule

// File: adcs_sequencer.sv
// Conversion sequencer for the two-stage 8-bit sampling converter
// How it works
// - Writing the start bit launches a conversion
// - A new start aborts and restarts conversion
// - New settings apply only at next start
// - Enable bit powers the converter up or down
// - Two sample rates, scaled by the clock
// - Rate chosen via control register index six
// - Dedicated sample timer paces every sample after the one a start launches
// - A conversion finishes within two microseconds
// - Auto-zero phase always precedes conversion phase
// - Upper nibble, then lower nibble, form result
`timescale 1ns/1ns
`include "adcs_params.svh"
module adcs_sequencer
    import adcs_pkg::*;
#(
    parameter int SLOW_PERIOD = `ADCS_PERIOD_LO_CYC,
    parameter int FAST_PERIOD = `ADCS_PERIOD_HI_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Processor external register port
    input adcs_ext_wr_t ext,
    output logic [7:0] ext_rdata,
    // Flash comparator outputs
    input wire logic [3:0] msb_flash,
    input wire logic [3:0] lsb_flash,
    // Analog phase controls
    output logic adc_power_en,
    output logic auto_zero,
    output logic msb_phase,
    output logic lsb_phase,
    // Result
    output logic [7:0] result,
    output logic result_valid,
    output logic busy
);
    localparam logic [7:0] AZ_LAST = 8'(`ADCS_AZ_CYC - 1);
    localparam logic [7:0] STAGE_LAST = 8'(`ADCS_STAGE_CYC - 1);
    function automatic logic ctrl_hit(input logic [2:0] addr);
        return addr == `ADCS_CTRL_INDEX;
    endfunction

    // Programmed and active settings
    adcs_ctrl_t analog_control_reg;
    adcs_ctrl_t next_analog_control_reg;
    adcs_ctrl_t act;
    adcs_ctrl_t next_act;
    logic start_cmd;

    always_comb begin
        next_analog_control_reg = analog_control_reg;
        next_act = act;
        start_cmd = ext.wr && ctrl_hit(ext.addr)
            && ext.data[`ADCS_BIT_START];
        if (ext.wr && ctrl_hit(ext.addr)) begin
            next_analog_control_reg.enable = ext.data[`ADCS_BIT_ENABLE];
            next_analog_control_reg.rate_hi = ext.data[`ADCS_BIT_RATE];
        end
        if (start_cmd) begin
            next_act = next_analog_control_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            analog_control_reg <= `ADCS_CTRL_RESET;
            act <= `ADCS_CTRL_RESET;
        end else if (ce) begin
            analog_control_reg <= next_analog_control_reg;
            act <= next_act;
        end
    end

    logic tick;
    adcs_sample_timer #(
        .SLOW_PERIOD(SLOW_PERIOD),
        .FAST_PERIOD(FAST_PERIOD)
    ) u_adcs_sample_timer (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .restart(start_cmd),
        .run(act.enable),
        .rate_hi(act.rate_hi),
        .tick(tick)
    );

    // Phase sequencer
    adcs_state_t state;
    adcs_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [3:0] msb_nib;
    logic [3:0] next_msb_nib;
    logic [7:0] next_result;
    logic next_result_valid;
    logic [7:0] next_ext_rdata;

    always_comb begin
        next_state = state;
        next_cnt = cnt + 8'h01;
        next_msb_nib = msb_nib;
        next_result = result;
        next_result_valid = 1'b0;
        unique case (state)
            ADCS_IDLE: begin
                next_cnt = 8'h00;
                if (tick) begin
                    next_state = ADCS_ZERO;
                end
            end
            ADCS_ZERO: begin
                if (cnt == AZ_LAST) begin
                    next_state = ADCS_MSB;
                    next_cnt = 8'h00;
                end
            end
            ADCS_MSB: begin
                if (cnt == STAGE_LAST) begin
                    next_msb_nib = msb_flash;
                    next_state = ADCS_LSB;
                    next_cnt = 8'h00;
                end
            end
            ADCS_LSB: begin
                if (cnt == STAGE_LAST) begin
                    next_result = {msb_nib, lsb_flash};
                    next_result_valid = 1'b1;
                    next_state = ADCS_IDLE;
                    next_cnt = 8'h00;
                end
            end
            default: begin
                next_state = ADCS_IDLE;
                next_cnt = 8'h00;
            end
        endcase
        if (start_cmd) begin
            next_state = next_act.enable ? ADCS_ZERO : ADCS_IDLE;
            next_cnt = 8'h00;
            next_result = result;
            next_result_valid = 1'b0;
        end
        next_ext_rdata = 8'h00;
        if (ctrl_hit(ext.addr)) begin
            next_ext_rdata[`ADCS_BIT_ENABLE] = analog_control_reg.enable;
            next_ext_rdata[`ADCS_BIT_RATE] = analog_control_reg.rate_hi;
            next_ext_rdata[`ADCS_BIT_BUSY] = state != ADCS_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ADCS_IDLE;
            cnt <= 8'h00;
            msb_nib <= 4'h0;
            result <= `ADCS_RESULT_RESET;
            result_valid <= 1'b0;
            ext_rdata <= 8'h00;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
            msb_nib <= next_msb_nib;
            result <= next_result;
            result_valid <= next_result_valid;
            ext_rdata <= next_ext_rdata;
        end
    end

    assign adc_power_en = act.enable;
    assign auto_zero = state == ADCS_ZERO;
    assign msb_phase = state == ADCS_MSB;
    assign lsb_phase = state == ADCS_LSB;
    assign busy = state != ADCS_IDLE;

    // Checking helpers; ce gating keeps them in step with the design
    logic [15:0] gap;
    logic gap_ok;
    logic [7:0] conv_age;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 16'h0000;
            gap_ok <= 1'b0;
            conv_age <= 8'h00;
        end else if (ce) begin
            gap <= (tick || start_cmd) ? 16'h0000 : gap + 16'h0001;
            gap_ok <= tick || start_cmd ? 1'b1 : gap_ok;
            conv_age <= (state == ADCS_MSB || state == ADCS_LSB)
                ? conv_age + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_start_launch;
        ce && start_cmd && next_act.enable |=> state == ADCS_ZERO && cnt == 0;
    endproperty
    a_start_launch: assert property (p_start_launch)
        else $error("start did not launch auto-zero");

    property p_abort;
        ce && start_cmd && busy |=> !result_valid && $stable(result)
            && state != ADCS_MSB && state != ADCS_LSB;
    endproperty
    a_abort: assert property (p_abort)
        else $error("start did not abort running conversion");

    property p_settings_hold;
        ce && !start_cmd |=> $stable(act);
    endproperty
    a_settings_hold: assert property (p_settings_hold)
        else $error("active settings changed without start");

    property p_power;
        state != ADCS_IDLE |-> adc_power_en && act.enable;
    endproperty
    a_power: assert property (p_power)
        else $error("converter running while disabled");

    property p_rate;
        tick && gap_ok |-> gap == (act.rate_hi ? 16'(FAST_PERIOD - 1)
            : 16'(SLOW_PERIOD - 1));
    endproperty
    a_rate: assert property (p_rate)
        else $error("sample period wrong for selected rate");

    property p_reg_index;
        ext.wr && !ctrl_hit(ext.addr) |=> $stable(analog_control_reg);
    endproperty
    a_reg_index: assert property (p_reg_index)
        else $error("control register changed by other index");

    property p_paced;
        state == ADCS_ZERO && $past(state) == ADCS_IDLE
            |-> $past(tick || start_cmd);
    endproperty
    a_paced: assert property (p_paced)
        else $error("sample began without timer or start");

    property p_conv_time;
        conv_age < 8'(`ADCS_CONV_MAX_CYC);
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion exceeded its time limit");

    property p_az_first;
        state == ADCS_MSB && $past(state) != ADCS_MSB
            |-> $past(state) == ADCS_ZERO;
    endproperty
    a_az_first: assert property (p_az_first)
        else $error("conversion entered without auto-zero");

    property p_nibbles;
        result_valid |-> result == {$past(msb_nib), $past(lsb_flash)};
    endproperty
    a_nibbles: assert property (p_nibbles)
        else $error("result not formed from the two stages");

    property p_no_partial;
        result != $past(result) |-> result_valid;
    endproperty
    a_no_partial: assert property (p_no_partial)
        else $error("result changed without a completed conversion");

    c_complete: cover property (result_valid);
    c_abort: cover property (ce && start_cmd && state == ADCS_MSB);
    c_fast: cover property (result_valid && act.rate_hi);
    c_tick: cover property (tick && state == ADCS_IDLE);
endmodule

// File: adcs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module adcs_sequencer_tb
    import adcs_pkg::*;
;
    localparam int SLOW = 400;
    localparam int FAST = 300;
    typedef struct {
        logic [7:0] data;
        logic [3:0] msb;
        logic [3:0] lsb;
        logic [7:0] res;
        int per;
    } adcs_row_t;
    adcs_row_t rows [4];
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic go = 1'b0;
    logic [2:0] go_addr = 3'h6;
    logic [7:0] go_data = 8'h00;
    logic [3:0] msb_code = 4'h0;
    logic [3:0] lsb_code = 4'h0;
    adcs_ext_wr_t ext;
    logic [7:0] ext_rdata;
    logic [7:0] result;
    logic [3:0] msb_flash;
    logic [3:0] lsb_flash;
    logic adc_power_en, auto_zero, msb_phase, lsb_phase, result_valid, busy;
    int mismatches = 0;
    int samples_checked = 0;
    int rv;
    int az;

    always #5 clock = ~clock;

    adcs_sequencer #(.SLOW_PERIOD(SLOW), .FAST_PERIOD(FAST)) u_adcs_sequencer (
        .clock(clock), .rst_n(rst_n), .ce(ce), .ext(ext),
        .ext_rdata(ext_rdata), .msb_flash(msb_flash), .lsb_flash(lsb_flash),
        .adc_power_en(adc_power_en), .auto_zero(auto_zero),
        .msb_phase(msb_phase), .lsb_phase(lsb_phase), .result(result),
        .result_valid(result_valid), .busy(busy));

    adcs_dsp_model u_adcs_dsp_model (
        .go(go), .go_addr(go_addr), .go_data(go_data),
        .msb_code(msb_code), .lsb_code(lsb_code), .msb_phase(msb_phase),
        .lsb_phase(lsb_phase), .ext(ext), .msb_flash(msb_flash),
        .lsb_flash(lsb_flash));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            mismatches++;
            $display("[ERR] %0t cycle %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        go <= 1'b1;
        go_addr <= a;
        go_data <= d;
        @(posedge clock);
        go <= 1'b0;
        go_addr <= 3'h6;
    endtask

    // Watches phases per cycle; optionally writes settings at cycle wk
    task automatic watch(input int lim, input bit run, input int wk,
                         input logic [7:0] wd);
        rv = 0;
        az = 0;
        for (int k = 1; k <= lim; k++) begin
            @(posedge clock);
            #1;
            if (run && k <= 200) begin
                chk8({5'h0, auto_zero, msb_phase, lsb_phase},
                     {5'h0, k < 100, k >= 100 && k < 150,
                      k >= 150 && k < 200});
            end
            if (result_valid === 1'b1 && rv == 0) rv = k;
            if (k > 201 && az == 0 && auto_zero === 1'b1) az = k;
            if (k == wk) begin
                go <= 1'b1;
                go_data <= wd;
            end
            if (k == wk + 1) go <= 1'b0;
        end
    endtask

    task automatic zeros;
        chk8({2'h0, adc_power_en, auto_zero, msb_phase, lsb_phase, busy,
              result_valid}, 8'h00);
        chk8(result, 8'h00);
        chk8(ext_rdata, 8'h00);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        rows = '{'{8'h05, 4'ha, 4'h5, 8'ha5, SLOW},
                 '{8'h07, 4'h3, 4'hc, 8'h3c, FAST},
                 '{8'h07, 4'hf, 4'h0, 8'hf0, FAST},
                 '{8'h05, 4'h0, 4'hf, 8'h0f, SLOW}};
        repeat (4) @(posedge clock);
        zeros();
        rst_n <= 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            msb_code <= rows[i].msb;
            lsb_code <= rows[i].lsb;
            wr(3'h6, rows[i].data);
            watch(rows[i].per + 10, 1'b1, 0, 8'h00);
            chkn(rv, 200);
            chk8(result, rows[i].res);
            chkn(az, rows[i].per);
            chk8({7'h0, adc_power_en}, 8'h01);
        end
        $display("test rows done");
        msb_code <= 4'h1;
        lsb_code <= 4'h2;
        wr(3'h6, 8'h05);
        watch(120, 1'b1, 0, 8'h00);
        chkn(rv, 0);
        chk8(result, 8'h0f);
        msb_code <= 4'h9;
        wr(3'h6, 8'h05);
        watch(250, 1'b1, 0, 8'h00);
        chkn(rv, 200);
        chk8(result, 8'h92);
        $display("test abort done");
        wr(3'h6, 8'h05);
        watch(410, 1'b1, 50, 8'h06);
        chkn(rv, 200);
        chkn(az, SLOW);
        repeat (2) @(posedge clock);
        #1;
        chk8(ext_rdata, 8'h0e);
        $display("test settings done");
        wr(3'h6, 8'h01);
        repeat (2) @(posedge clock);
        #1;
        chk8({6'h0, adc_power_en, busy}, 8'h00);
        watch(450, 1'b0, 0, 8'h00);
        chkn(az + rv, 0);
        wr(3'h5, 8'h05);
        watch(450, 1'b0, 0, 8'h00);
        chkn(az + rv, 0);
        chk8({7'h0, busy}, 8'h00);
        $display("test disable done");
        // Clock enable low must freeze the phase counter mid auto-zero
        wr(3'h6, 8'h05);
        watch(60, 1'b1, 0, 8'h00);
        ce <= 1'b0;
        repeat (20) @(posedge clock);
        #1;
        chk8({6'h0, auto_zero, busy}, 8'h03);
        ce <= 1'b1;
        watch(150, 1'b0, 0, 8'h00);
        chkn(rv, 140);
        chk8(result, 8'h92);
        $display("test freeze done");
        wr(3'h6, 8'h05);
        watch(60, 1'b1, 0, 8'h00);
        rst_n <= 1'b0;
        @(posedge clock);
        #1;
        zeros();
        rst_n <= 1'b1;
        wr(3'h6, 8'h05);
        watch(250, 1'b1, 0, 8'h00);
        chkn(rv, 200);
        $display("test midreset done");
        test_done();
    end
endmodule
